// ===== l2_cache_lru_replacement_test.sv
/*
 Self-checking bench of the replacement controller: fills, hits, mapped
 RAM and DMA traffic, block commands, random allocations.
 Assumes the host model drives all requests; victims are checked in order.
*/
`timescale 1ns/100ps
module l2_cache_lru_replacement_test;
    logic              clock = 1'b0;
    logic              rst_n = 1'b0;
    logic [1:0]        mode = 2'h3;
    lrr_pkg::lrr_req_t req;
    logic              valid, ready, hit, alloc, dirty, vv, wbv, is_ram, busy;
    logic [1:0]        hway, vway, wway, wb_w;
    logic [5:0]        vset, wset, wb_s;
    logic [1:0]        age [64][4];
    bit                vld [64][4];
    logic [7:0]        vq [$];
    int                fails = 0, compares = 0, cyc = 0, wb_n = 0, seed = 9;

    always #50 clock = ~clock;

    lrr_ctrl u_lrr_ctrl (.i_clock(clock), .i_rst_n(rst_n), .i_req_valid(valid), .o_req_ready(ready),
        .i_req(req), .i_hit(hit), .i_hit_way(hway), .i_alloc(alloc), .i_line_dirty(dirty),
        .i_cache_mode(mode), .i_ram_base_sel(1'b0), .o_victim_valid(vv), .o_victim_way(vway),
        .o_victim_set(vset), .o_wb_valid(wbv), .o_wb_set(wset), .o_wb_way(wway), .o_is_ram(is_ram),
        .o_blk_busy(busy));

    lrr_host_model u_lrr_host_model (.i_clock(clock), .i_ready(ready), .i_wb_valid(wbv), .o_req(req),
        .o_req_valid(valid), .o_hit(hit), .o_hit_way(hway), .o_alloc(alloc), .o_line_dirty(dirty));

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Reference recency: promote way to most recent
    task automatic promote(input int s, input int w);
        logic [1:0] old;
        old = age[s][w];
        for (int k = 0; k < 4; k++)
            if (age[s][k] > old)
                age[s][k]--;
        age[s][w] = 2'h3;
    endtask

    task automatic cpu_alloc(input logic [31:0] a);
        int s, w;
        s = a[12:7];
        w = -1;
        for (int k = 3; k >= 0; k--)
            if (!vld[s][k])
                w = k;
        for (int k = 0; k < 4; k++)
            if (w < 0 && age[s][k] == 2'h0)
                w = k;
        vq.push_back({w[1:0], s[5:0]});
        vld[s][w] = 1'b1;
        promote(s, w);
        u_lrr_host_model.send(2'h0, 2'h0, a, 1'b0, 2'h0, 1'b1);
    endtask

    task automatic cpu_hit(input logic [31:0] a, input int w);
        promote(a[12:7], w);
        u_lrr_host_model.send(2'h0, 2'h0, a, 1'b1, w[1:0], 1'b0);
    endtask

    task automatic blk(input logic [1:0] op, input logic [31:0] a);
        u_lrr_host_model.send(2'h0, op, a, 1'b0, 2'h0, 1'b0);
        repeat (2) @(posedge clock);
        for (int n = 0; n < 200 && busy !== 1'b0; n++)
            @(posedge clock);
        check("blk_done", busy, 1'b0);
        for (int k = 0; k < 4; k++)
            vld[a[12:7]][k] = 1'b0;
    endtask

    // Victim and writeback monitor, plus run ceiling
    always @(posedge clock)
    begin
        logic [7:0] e;
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            finish_test();
        end
        if (vv === 1'b1 && vq.size() == 0)
            check("victim_extra", 1'b1, 1'b0);
        else if (vv === 1'b1)
        begin
            e = vq.pop_front();
            check("victim_way", 32'(vway), 32'(e[7:6]));
            check("victim_set", 32'(vset), 32'(e[5:0]));
        end
        if (wbv === 1'b1)
        begin
            wb_n++;
            wb_s = wset;
            wb_w = wway;
        end
    end

    initial
    begin
        for (int s = 0; s < 64; s++)
            for (int k = 0; k < 4; k++)
                age[s][k] = k[1:0];
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        for (int n = 0; n < 100 && ready !== 1'b1; n++)
            @(posedge clock);
        check("ready_init", ready, 1'b1);
        // Fill one set, then evict the oldest
        for (int i = 0; i < 5; i++)
            cpu_alloc(32'h8000_0280);
        $display("test fill done");
        // Hit, neighbour hit, RAM and DMA traffic, then evict
        cpu_hit(32'h8000_0280, 1);
        cpu_hit(32'h8000_0280, 2);
        cpu_hit(32'h8000_0280, 3);
        cpu_hit(32'h8000_0200, 0);
        u_lrr_host_model.send(2'h0, 2'h0, 32'h0003_0280, 1'b1, 2'h0, 1'b1);
        u_lrr_host_model.send(2'h1, 2'h0, 32'h8000_0280, 1'b1, 2'h0, 1'b1);
        cpu_alloc(32'h8000_0280);
        $display("test recency done");
        // Block commands free the set
        blk(2'h1, 32'h8000_0280);
        cpu_alloc(32'h8000_0280);
        u_lrr_host_model.arm();
        blk(2'h2, 32'h8000_0280);
        check("wb_count", wb_n, 1);
        check("wb_set", 32'(wb_s), 32'h5);
        check("wb_way", 32'(wb_w), 32'h0);
        cpu_alloc(32'h8000_0280);
        $display("test block done");
        // Mapped RAM decode for every cache size
        for (int m = 0; m < 4; m++)
            for (int k = 0; k < 4; k++)
            begin
                u_lrr_host_model.show({14'h0, k[1:0], 16'h0280});
                mode <= m[1:0];
                @(negedge clock);
                check("is_ram", is_ram, k >= m);
            end
        mode <= 2'h3;
        $display("test decode done");
        // Random external traffic
        for (int i = 0; i < 16; i++)
            if ($random(seed) & 1)
                cpu_alloc({4'h8, 28'($random(seed))});
            else
                cpu_hit({4'h8, 28'($random(seed))}, i % 4);
        repeat (4) @(posedge clock);
        check("queue_empty", vq.size(), 0);
        $display("test random done");
        finish_test();
    end
endmodule

// ===== lrr_age_upd.sv
/*
 * Recency update for one set: promotes one way to most recent.
 * Assumes the ages held are a permutation of 0..3 (3 is most recent).
 */
`timescale 1ns/100ps
module lrr_age_upd
#(
    parameter int WAYS  = 4,
    parameter int AW    = 2
)
(
    input  wire logic [WAYS*AW-1:0] i_ages,
    input  wire logic [1:0]         i_way,
    output logic      [WAYS*AW-1:0] o_ages,
    output logic      [1:0]         o_lru_way
);

    logic [AW-1:0] hit_age;

    // Ages above the promoted way slide down by one
    always_comb
    begin
        hit_age   = i_ages[i_way*AW +: AW];
        o_ages    = i_ages;
        o_lru_way = 2'h0;
        for (int w = 0; w < WAYS; w++)
        begin
            if (i_ages[w*AW +: AW] > hit_age)
            begin
                o_ages[w*AW +: AW] = i_ages[w*AW +: AW] - 2'h1;
            end
            if (i_ages[w*AW +: AW] == 2'h0)
            begin
                o_lru_way = w[1:0];
            end
        end
        o_ages[i_way*AW +: AW] = 2'h3;
    end

endmodule

// ===== lrr_ctrl.sv
/*
 * Replacement controller of a 4-way set-associative second-level cache:
 * recency tracking, victim choice, block invalidate commands.
 * Assumes tags are looked up outside and reported as hit and hit way;
 * requests come from the core or DMA on the same clock.
 */
`timescale 1ns/100ps
module lrr_ctrl
#(
    parameter int SETS = lrr_pkg::NUM_SETS
)
(
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    input  wire logic              i_req_valid,
    output logic                   o_req_ready,
    input  wire lrr_pkg::lrr_req_t i_req,
    input  wire logic              i_hit,        // Tag lookup result for i_req
    input  wire logic [1:0]        i_hit_way,
    input  wire logic              i_alloc,      // Miss that needs a line
    input  wire logic              i_line_dirty, // Dirty flag of line being removed
    input  wire logic [1:0]        i_cache_mode, // Ways given to cache: 0 none .. 3 three of four
    input  wire logic              i_ram_base_sel,
    output logic                   o_victim_valid,
    output logic [1:0]             o_victim_way,
    output logic [5:0]             o_victim_set,
    output logic                   o_wb_valid,
    output logic [5:0]             o_wb_set,
    output logic [1:0]             o_wb_way,
    output logic                   o_is_ram,
    output logic                   o_blk_busy
);

    localparam int RW = lrr_pkg::GROUP_SETS * lrr_pkg::NUM_WAYS * lrr_pkg::AGE_W;
    localparam int SW = lrr_pkg::NUM_WAYS * lrr_pkg::AGE_W;

    // Recency rows, four sets each, and valid bits per set
    logic [RW-1:0]            age_mem [SETS/lrr_pkg::GROUP_SETS];
    logic [lrr_pkg::NUM_WAYS-1:0] vld_q [SETS];
    lrr_pkg::lrr_state_t      st_q;
    logic [lrr_pkg::ADDR_W-1:0] blk_q;
    logic [lrr_pkg::ADDR_W-1:0] blk_end_q;
    logic                     blk_wb_q;
    logic [1:0]               blk_way_q;
    logic [1:0]               vict_q;
    logic                     vict_v_q;
    logic [5:0]               vset_q;
    logic                     wb_v_q;
    logic [5:0]               wb_set_q;
    logic [1:0]               wb_way_q;
    logic                     init_q;
    logic [4:0]               init_row_q;

    // Set index from address; same for RAM and external addresses
    function automatic logic [5:0] set_of(input logic [lrr_pkg::ADDR_W-1:0] a);
        set_of = a[lrr_pkg::LINE_OFF_BITS +: lrr_pkg::SET_W];
    endfunction

    // Mapped RAM is the part of L2 not given to cache; top address nibble of zero picks L2
    function automatic logic ram_of(input logic [lrr_pkg::ADDR_W-1:0] a, input logic [1:0] m);
        ram_of = (a[31:28] == 4'h0) && (a[17:16] >= m);
    endfunction

    wire [5:0] req_set    = set_of(i_req.addr);
    wire [3:0] req_row    = req_set[5:2];
    wire [1:0] req_col    = req_set[1:0];
    wire       req_ram    = ram_of(i_req.addr, i_cache_mode);
    wire       acc_fire   = i_req_valid && o_req_ready && (i_req.op == lrr_pkg::LRR_OP_ACCESS);
    wire       cpu_cache  = acc_fire && (i_req.src == lrr_pkg::LRR_SRC_CPU) && !req_ram;
    wire       upd_hit    = cpu_cache && i_hit;
    wire       upd_alloc  = cpu_cache && !i_hit && i_alloc;
    wire [RW-1:0] row_q   = age_mem[req_row];
    wire [SW-1:0] set_age = row_q[req_col*SW +: SW];
    wire [3:0] set_vld    = vld_q[req_set];
    wire       has_inv    = ~&set_vld;
    logic [1:0] inv_way;
    wire [1:0] lru_way;
    wire [SW-1:0] new_age;
    wire [1:0] alloc_way  = has_inv ? inv_way : lru_way;
    wire [1:0] touch_way  = upd_hit ? i_hit_way : alloc_way;
    wire [5:0] bset       = set_of(blk_q);

    // Lowest invalid way
    always_comb
    begin
        inv_way = 2'h0;
        for (int w = lrr_pkg::NUM_WAYS - 1; w >= 0; w--)
        begin
            if (!set_vld[w])
            begin
                inv_way = w[1:0];
            end
        end
    end

    lrr_age_upd #(.WAYS(lrr_pkg::NUM_WAYS), .AW(lrr_pkg::AGE_W)) u_upd
    (
        .i_ages    (set_age),
        .i_way     (touch_way),
        .o_ages    (new_age),
        .o_lru_way (lru_way)
    );

    assign o_req_ready  = (st_q == lrr_pkg::LRR_ST_IDLE) && !init_q;
    assign o_blk_busy   = (st_q != lrr_pkg::LRR_ST_IDLE) || init_q;
    assign o_is_ram     = req_ram;
    assign o_victim_valid = vict_v_q;
    assign o_victim_way = vict_q;
    assign o_victim_set = vset_q;
    assign o_wb_valid   = wb_v_q;
    assign o_wb_set     = wb_set_q;
    assign o_wb_way     = wb_way_q;

    // Recency rows: whole rows during init, else only the touched set's slice is rewritten
    always_ff @(posedge i_clock)
    begin
        if (init_q)
        begin
            age_mem[init_row_q[3:0]] <= {lrr_pkg::GROUP_SETS{lrr_pkg::AGE_RESET}};
        end
        else if (upd_hit || upd_alloc)
        begin
            age_mem[req_row][req_col*SW +: SW] <= new_age;
        end
    end

    // Row initialisation after reset
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            init_q     <= 1'b1;
            init_row_q <= 5'h00;
        end
        else if (init_q)
        begin
            init_row_q <= init_row_q + 5'h01;
            init_q     <= (init_row_q != 5'(SETS/lrr_pkg::GROUP_SETS - 1));
        end
    end

    // Valid bits: allocation sets, block commands clear
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            for (int s = 0; s < SETS; s++)
            begin
                vld_q[s] <= lrr_pkg::INV_ALL[3:0];
            end
        end
        else if (upd_alloc)
        begin
            vld_q[req_set][alloc_way] <= 1'b1;
        end
        else if (st_q == lrr_pkg::LRR_ST_BLK && !(blk_wb_q && i_line_dirty && vld_q[bset][blk_way_q]))
        begin
            vld_q[bset][blk_way_q] <= 1'b0;
        end
    end

    // Victim report for the tag side
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            vict_v_q <= 1'b0;
            vict_q   <= 2'h0;
            vset_q   <= 6'h00;
        end
        else
        begin
            vict_v_q <= upd_alloc;
            vict_q   <= alloc_way;
            vset_q   <= req_set;
        end
    end

    // Block command walker: every way of every set in range
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            st_q      <= lrr_pkg::LRR_ST_IDLE;
            blk_q     <= 32'h0000_0000;
            blk_end_q <= 32'h0000_0000;
            blk_wb_q  <= 1'b0;
            blk_way_q <= 2'h0;
            wb_v_q    <= 1'b0;
            wb_set_q  <= 6'h00;
            wb_way_q  <= 2'h0;
        end
        else
        begin
            wb_v_q <= 1'b0;
            unique case (st_q)
                lrr_pkg::LRR_ST_IDLE:
                begin
                    if (i_req_valid && o_req_ready && i_req.op != lrr_pkg::LRR_OP_ACCESS)
                    begin
                        st_q      <= lrr_pkg::LRR_ST_BLK;
                        blk_q     <= i_req.addr;
                        blk_end_q <= i_req.last;
                        blk_wb_q  <= (i_req.op == lrr_pkg::LRR_OP_WBINV);
                        blk_way_q <= 2'h0;
                    end
                end
                lrr_pkg::LRR_ST_BLK:
                begin
                    if (blk_wb_q && i_line_dirty && vld_q[bset][blk_way_q])
                    begin
                        st_q     <= lrr_pkg::LRR_ST_WB;
                        wb_v_q   <= 1'b1;
                        wb_set_q <= bset;
                        wb_way_q <= blk_way_q;
                    end
                    else if (blk_way_q != 2'h3)
                    begin
                        blk_way_q <= blk_way_q + 2'h1;
                    end
                    else if (blk_q[31:7] >= blk_end_q[31:7])
                    begin
                        st_q <= lrr_pkg::LRR_ST_IDLE;
                    end
                    else
                    begin
                        blk_way_q <= 2'h0;
                        blk_q     <= blk_q + 32'h0000_0080;
                    end
                end
                lrr_pkg::LRR_ST_WB:
                begin
                    st_q <= lrr_pkg::LRR_ST_BLK;   // Line cleaned; dirty must drop next cycle
                end
                default:
                begin
                    st_q <= lrr_pkg::LRR_ST_IDLE;
                end
            endcase
        end
    end

    // Checks
    chk_dma_no_victim: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (acc_fire && i_req.src == lrr_pkg::LRR_SRC_DMA) |=> !o_victim_valid)
        else $error("DMA access produced a victim");
    chk_ram_no_victim: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (acc_fire && req_ram) |=> !o_victim_valid)
        else $error("RAM access produced a victim");
    chk_inv_first: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (upd_alloc && !set_vld[0]) |=> (o_victim_way == 2'h0))
        else $error("Invalid way 0 not chosen");
    chk_lru_evict: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (upd_alloc && &set_vld) |=> (o_victim_way == $past(lru_way)))
        else $error("Victim is not least recent way");
    chk_hit_mru: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        upd_hit |-> (new_age[i_hit_way*2 +: 2] == 2'h3))
        else $error("Hit way not made most recent");
    chk_wb_then_blk: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_wb_valid |-> (st_q == lrr_pkg::LRR_ST_WB) ##1 (st_q == lrr_pkg::LRR_ST_BLK))
        else $error("Writeback sequence broken");
    chk_busy_no_ready: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_req_valid && o_req_ready && i_req.op != lrr_pkg::LRR_OP_ACCESS) |=> (o_blk_busy && !o_req_ready))
        else $error("Block command did not stall requests");
    chk_set_index: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        upd_alloc |=> (o_victim_set == $past(i_req.addr[12:7])))
        else $error("Wrong set index");

    cov_hit: cover property (@(posedge i_clock) disable iff (!i_rst_n) upd_hit);
    cov_full_evict: cover property (@(posedge i_clock) disable iff (!i_rst_n) upd_alloc && &set_vld);
    cov_wb: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_wb_valid);

endmodule

// ===== lrr_host_model.sv
/*
 Requesting side of the replacement controller: core and DMA requests
 with tag lookup answers, plus dirty flags during block walks.
 Assumes the bench calls its tasks and one shared clock.
*/
`timescale 1ns/100ps
module lrr_host_model
(
    input  wire logic         i_clock,
    input  wire logic         i_ready,
    input  wire logic         i_wb_valid,
    output lrr_pkg::lrr_req_t o_req,
    output logic              o_req_valid,
    output logic              o_hit,
    output logic [1:0]        o_hit_way,
    output logic              o_alloc,
    output logic              o_line_dirty
);
    // Idle request and clean lines at start
    initial
    begin
        o_req = '0;
        o_req_valid = 1'b0;
        o_hit = 1'b0;
        o_hit_way = 2'h0;
        o_alloc = 1'b0;
        o_line_dirty = 1'b0;
    end

    // Dirty flag drops once the line was written back
    always @(posedge i_clock)
    begin
        if (i_wb_valid === 1'b1)
            o_line_dirty <= 1'b0;
    end

    // One request held until ready, then released with address, hit and way inverted, alloc cleared
    task automatic send(input logic [1:0] s, input logic [1:0] op, input logic [31:0] a, input logic h,
                        input logic [1:0] w, input logic al);
        @(posedge i_clock);
        o_req <= {s, op, a, a};
        o_req_valid <= 1'b1;
        o_hit <= h;
        o_hit_way <= w;
        o_alloc <= al;
        do @(posedge i_clock); while (i_ready !== 1'b1);
        o_req_valid <= 1'b0;
        o_req.addr <= ~a;
        o_hit <= ~h;
        o_hit_way <= ~w;
        o_alloc <= 1'b0;
    endtask

    // Address only, for the mapped-RAM decode
    task automatic show(input logic [31:0] a);
        @(posedge i_clock);
        o_req.addr <= a;
    endtask

    // Mark the next walked line dirty
    task automatic arm();
        @(posedge i_clock);
        o_line_dirty <= 1'b1;
    endtask
endmodule

// ===== lrr_pkg.sv
/*
 * Package for the second-level cache replacement block: geometry,
 * reset values, request carrier and controller states.
 * Assumes a single clock domain and no software-visible registers.
 */
package lrr_pkg;

    localparam int ADDR_W        = 32;
    localparam int NUM_WAYS      = 4;
    localparam int WAY_W         = 2;
    localparam int AGE_W         = 2;
    localparam int LINE_OFF_BITS = 7;                 // 128-byte line: 4 sets span 512 bytes
    localparam int SET_W         = 6;
    localparam int NUM_SETS      = 64;
    localparam int GROUP_SETS    = 4;
    localparam int GROUP_W       = 2;
    localparam int MODE_W        = 2;
    localparam logic [7:0] AGE_RESET = 8'hE4;         // Way n starts with age n
    localparam logic [7:0] INV_ALL   = 8'h00;

    typedef enum logic [1:0]
    {
        LRR_SRC_CPU = 2'h0,
        LRR_SRC_DMA = 2'h1
    } lrr_src_t;

    typedef enum logic [1:0]
    {
        LRR_OP_ACCESS = 2'h0,
        LRR_OP_INV    = 2'h1,
        LRR_OP_WBINV  = 2'h2
    } lrr_op_t;

    typedef struct packed
    {
        lrr_src_t            src;
        lrr_op_t             op;
        logic [ADDR_W-1:0]   addr;
        logic [ADDR_W-1:0]   last;
    } lrr_req_t;

    typedef enum logic [1:0]
    {
        LRR_ST_IDLE = 2'b00,
        LRR_ST_BLK  = 2'b01,
        LRR_ST_WB   = 2'b11
    } lrr_state_t;

endpackage
